// ### shared/reader_status_pkg.sv
/*
  Constants for the reader status and test register bank: register offsets,
  field positions, reset values, page and measurement codes.
  Assumes a byte-wide host register port with a 6-bit register address.
*/
package reader_status_pkg;
  // Register addresses
  localparam logic [5:0] ADDR_GAIN_STATUS = 6'h0e;
  localparam logic [5:0] ADDR_SIGNAL_STRENGTH = 6'h0f;
  localparam logic [5:0] ADDR_LIMIT_OR_OSC = 6'h10;
  localparam logic [5:0] ADDR_MEASURE_SELECT = 6'h11;
  localparam logic [5:0] ADDR_TEST_SETTING = 6'h12;
  localparam logic [5:0] ADDR_CHIP_VERSION = 6'h13;
  // Reset values
  localparam logic [2:0] MEASURE_RESET = 3'h0;
  localparam logic [23:0] TEST_SETTING_RESET = 24'h000000;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // Byte pointer of the three-byte test setting register
  localparam logic [1:0] TSET_BYTE_FIRST = 2'h0;
  localparam logic [1:0] TSET_BYTE_LAST = 2'h2;
  localparam logic [1:0] TSET_BYTE_STEP = 2'h1;
  // Test setting field positions (low bit of each field)
  localparam int TS_TEST_GROUP_A = 21;
  localparam int TS_TEST_GROUP_B = 18;
  localparam int TS_DECODER_SPEEDUP = 16;
  localparam int TS_PAGE_SELECT = 14;
  localparam int TS_STRENGTH_CONT = 13;
  localparam int TS_GAIN_CONTROL_TYPE = 12;
  localparam int TS_RX_BLOCK = 10;
  localparam int TS_DIG_FILTER_OFF = 9;
  localparam int TS_SUBC_IN = 4;
  localparam int TS_SUBC_OUT = 3;
  localparam int TS_PRESCALER_TEST = 2;
  localparam int TS_EXTRA_TEST = 0;
  // Mask of writable test setting bits; bits 17 and 8:5 are reserved
  localparam logic [23:0] TEST_SETTING_MASK = 24'hfd_fe1f;
  // Page select codes for the shared status register
  localparam logic [1:0] PAGE_GAIN_LIMIT = 2'h0;
  localparam logic [1:0] PAGE_OSC_RANGE = 2'h1;
  // Measurement source codes
  localparam logic [2:0] MEAS_NONE = 3'h0;
  localparam logic [2:0] MEAS_I_MIXER_DC = 3'h1;
  localparam logic [2:0] MEAS_Q_MIXER_DC = 3'h2;
  localparam logic [2:0] MEAS_ADC_PIN = 3'h3;
  localparam logic [2:0] MEAS_RF_LEVEL = 3'h4;
  localparam logic [2:0] MEAS_EXTERNAL_SUPPLY_LEVEL = 3'h7;
  // Width of the synchronised analog status vector
  localparam int STATUS_IN_W = 31;
endpackage

// ### tb/host_model.sv
/*
  Host controller model for the reader status register bank: byte reads
  and writes on the register port, and the access_end pulse.
  Assumes clk_sys from the bench; it drives on the falling edge only.
*/
`timescale 1ns/1ps
module host_model (
  // Clock and read data
  input wire logic clk_sys,
  input wire logic [7:0] reg_rd_data,
  // Register port driven by the host
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wr_data,
  output logic reg_rd,
  output logic access_end
);
  initial begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd = 1'b0;
    access_end = 1'b0;
  end

  // One byte access; address and data are inverted once released so a
  // design that samples them late sees wrong values, not stale ones
  task automatic xfer(input logic [5:0] a, input logic wr, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wr = wr;
    reg_rd = !wr;
    reg_wr_data = d;
    @(negedge clk_sys);
    q = reg_rd_data;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask

  // Three writes on consecutive edges, the back-to-back case of the port;
  // the strobe stays up and only the data byte moves between edges
  task automatic burst(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wr = 1'b1;
    reg_rd = 1'b0;
    for (int k = 2; k >= 0; k--) begin
      reg_wr_data = d[k*8 +: 8];
      @(negedge clk_sys);
    end
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d[7:0];
  endtask

  // End of host access, rewinds the three-byte pointer
  task automatic fin();
    @(negedge clk_sys);
    access_end = 1'b1;
    @(negedge clk_sys);
    access_end = 1'b0;
  endtask
endmodule

// ### tb/tb_top.sv
/*
  Self-checking bench for the reader status and test register bank.
  Assumes the host model drives the register port; status inputs are
  random levels held long enough to pass the 2-flop synchronisers.
*/
`timescale 1ns/1ps
module tb_top;
  import reader_status_pkg::*;
  localparam logic [7:0] VERSION_VALUE = 8'ha7;  // Arbitrary identification value
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic chip_en = 1'b1;
  logic rx_active = 1'b0;
  logic [29:0] st = 30'h0;  // Packed analog status levels
  logic [8:0] held = 9'h0;  // Subcarrier source and strengths latched in reception
  logic [5:0] reg_addr;
  logic reg_wr, reg_rd, access_end;
  logic [7:0] reg_wr_data, reg_rd_data, q;
  logic [2:0] measure_source, analog_test_group_a, analog_test_group_b;
  logic [1:0] status_page_select, rx_output_block, extra_test;
  logic decoder_speedup, strength_continuous, gain_control_type, digital_filter_off;
  logic subc_input_enable, subc_output_enable, prescaler_test;
  logic [23:0] v, r;
  logic [2:0] codes [6] = '{MEAS_NONE, MEAS_I_MIXER_DC, MEAS_Q_MIXER_DC, MEAS_ADC_PIN,
                            MEAS_RF_LEVEL, MEAS_EXTERNAL_SUPPLY_LEVEL};
  int err_total = 0;
  int checks = 0;
  // Test setting outputs gathered in register bit order; reserved bits read 0
  wire [23:0] ts_out = {analog_test_group_a, analog_test_group_b, 1'b0, decoder_speedup,
    status_page_select, strength_continuous, gain_control_type, rx_output_block,
    digital_filter_off, 4'h0, subc_input_enable, subc_output_enable, prescaler_test,
    extra_test};

  always #5 clk_sys = ~clk_sys;

  host_model u_host_model (.clk_sys(clk_sys), .reg_rd_data(reg_rd_data),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .reg_rd(reg_rd),
    .access_end(access_end));

  reader_status_test_registers #(.CHIP_VERSION(VERSION_VALUE)) u_reader_status_test_registers (
    .clk_sys(clk_sys), .rst(rst), .chip_en(chip_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wr_data(reg_wr_data), .reg_rd(reg_rd), .access_end(access_end),
    .reg_rd_data(reg_rd_data), .rx_active(rx_active), .gain_level(st[29:26]),
    .subc_from_q(st[25]), .rf_level_stable(st[24]), .pll_locked(st[23]),
    .osc_stable(st[22]), .strength_q(st[21:18]), .strength_i(st[17:14]),
    .gain_limit_i(st[13:11]), .gain_limit_q(st[10:8]), .osc_range_result(st[7:4]),
    .osc_double_freq(st[3]), .tune_voltage_code(st[2:0]),
    .measure_source(measure_source), .analog_test_group_a(analog_test_group_a),
    .analog_test_group_b(analog_test_group_b), .decoder_speedup(decoder_speedup),
    .status_page_select(status_page_select), .strength_continuous(strength_continuous),
    .gain_control_type(gain_control_type), .rx_output_block(rx_output_block),
    .digital_filter_off(digital_filter_off), .subc_input_enable(subc_input_enable),
    .subc_output_enable(subc_output_enable), .prescaler_test(prescaler_test),
    .extra_test(extra_test));

  // Expected gain and internal status byte; bit 3 comes from the held source
  function automatic logic [7:0] exp_gain(input logic [29:0] s, input logic [8:0] h);
    return {s[29:26], h[8], s[24:22]};
  endfunction

  // Expected shared status byte for a page code; unused pages read zero
  function automatic logic [7:0] exp_page(input logic [1:0] p, input logic [29:0] s);
    case (p)
      PAGE_GAIN_LIMIT: return {2'h0, s[13:8]};
      PAGE_OSC_RANGE: return s[7:0];
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    u_host_model.xfer(a, 1'b0, 8'h00, q);
    chk({16'h0, q}, {16'h0, exp});
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host_model.xfer(a, 1'b1, d, q);
  endtask

  // Three bytes, most significant first, then rewind the pointer; an odd
  // value goes out as one back-to-back burst, an even one byte by byte
  task automatic wts(input logic [23:0] d);
    if (d[0]) begin
      u_host_model.burst(ADDR_TEST_SETTING, d);
    end else begin
      wr(ADDR_TEST_SETTING, d[23:16]);
      wr(ADDR_TEST_SETTING, d[15:8]);
      wr(ADDR_TEST_SETTING, d[7:0]);
    end
    u_host_model.fin();
  endtask

  task automatic rts(output logic [23:0] d);
    for (int k = 2; k >= 0; k--) begin
      u_host_model.xfer(ADDR_TEST_SETTING, 1'b0, 8'h00, q);
      d[k*8 +: 8] = q;
    end
    u_host_model.fin();
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    #200us;
    err_total++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h5ff9));
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    rdchk(ADDR_MEASURE_SELECT, 8'h00);
    rts(r);
    chk(r, TEST_SETTING_RESET);
    chk(ts_out, TEST_SETTING_RESET);
    rdchk(ADDR_CHIP_VERSION, VERSION_VALUE);
    rdchk(6'h3f, READ_IDLE);
    // Status in and out of reception, every page code including unused ones
    for (int i = 0; i < 8; i++) begin
      st = 30'($urandom);
      rx_active = 1'b1;
      held = {st[25], st[21:14]};
      repeat (4) @(negedge clk_sys);
      rdchk(ADDR_GAIN_STATUS, exp_gain(st, held));
      rdchk(ADDR_SIGNAL_STRENGTH, held[7:0]);
      rx_active = 1'b0;
      repeat (4) @(negedge clk_sys);
      st = 30'($urandom);
      repeat (4) @(negedge clk_sys);
      rdchk(ADDR_GAIN_STATUS, exp_gain(st, held));
      rdchk(ADDR_SIGNAL_STRENGTH, held[7:0]);
      v = 24'($urandom);
      v[15:14] = 2'(i);
      wts(v);
      chk(ts_out, v & TEST_SETTING_MASK);
      rts(r);
      chk(r, v & TEST_SETTING_MASK);
      rdchk(ADDR_LIMIT_OR_OSC, exp_page(v[15:14], st));
    end
    // Every measurement source code, reserved bits written high
    foreach (codes[j]) begin
      wr(ADDR_MEASURE_SELECT, {5'h1f, codes[j]});
      chk({21'h0, measure_source}, {21'h0, codes[j]});
      rdchk(ADDR_MEASURE_SELECT, {5'h00, codes[j]});
    end
    // Writes to read-only and unmapped places change nothing
    for (int a = 6'h0e; a <= 6'h13; a++) begin
      if (a != 6'h11 && a != 6'h12) wr(6'(a), 8'($urandom));
    end
    wr(6'h3f, 8'h00);
    rdchk(ADDR_CHIP_VERSION, VERSION_VALUE);
    rdchk(ADDR_GAIN_STATUS, exp_gain(st, held));
    rdchk(ADDR_SIGNAL_STRENGTH, held[7:0]);
    rdchk(ADDR_MEASURE_SELECT, {5'h00, MEAS_EXTERNAL_SUPPLY_LEVEL});
    rdchk(ADDR_LIMIT_OR_OSC, exp_page(v[15:14], st));
    chk(ts_out, v & TEST_SETTING_MASK);
    // Chip enable low clears the configuration
    wts(24'hffffff);
    chk(ts_out, TEST_SETTING_MASK);
    chip_en = 1'b0;
    repeat (4) @(negedge clk_sys);
    chip_en = 1'b1;
    repeat (4) @(negedge clk_sys);
    rdchk(ADDR_MEASURE_SELECT, 8'h00);
    chk(ts_out, TEST_SETTING_RESET);
    rts(r);
    chk(r, TEST_SETTING_RESET);
    wts(24'h000000);
    tally_and_finish();
  end
endmodule

// ### verilog/reader_status_test_registers.sv
/*
  Bank of receiver and synthesizer status registers and the test and
  measurement configuration registers of the reader chip.
  Assumes the host port logic delivers byte reads and writes on clk_sys
  with an access_end pulse at the end of each host access, and that the
  analog status inputs are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module reader_status_test_registers
  import reader_status_pkg::*;
#(
  parameter logic [7:0] CHIP_VERSION = 8'h5a  // Arbitrary identification value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_en,
  // Host register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd,
  input wire logic access_end,
  output logic [7:0] reg_rd_data,
  // Receiver and synthesizer status from the analog side
  input wire logic rx_active,
  input wire logic [3:0] gain_level,
  input wire logic subc_from_q,
  input wire logic rf_level_stable,
  input wire logic pll_locked,
  input wire logic osc_stable,
  input wire logic [3:0] strength_i,
  input wire logic [3:0] strength_q,
  input wire logic [2:0] gain_limit_i,
  input wire logic [2:0] gain_limit_q,
  input wire logic [3:0] osc_range_result,
  input wire logic osc_double_freq,
  input wire logic [2:0] tune_voltage_code,
  // Configuration outputs
  output logic [2:0] measure_source,
  output logic [2:0] analog_test_group_a,
  output logic [2:0] analog_test_group_b,
  output logic decoder_speedup,
  output logic [1:0] status_page_select,
  output logic strength_continuous,
  output logic gain_control_type,
  output logic [1:0] rx_output_block,
  output logic digital_filter_off,
  output logic subc_input_enable,
  output logic subc_output_enable,
  output logic prescaler_test,
  output logic [1:0] extra_test
);

  // Asynchronous status gathered into one vector for the synchroniser
  logic [STATUS_IN_W-1:0] status_raw;
  logic [STATUS_IN_W-1:0] sync_a;  // First stage, read only by sync_b
  logic [STATUS_IN_W-1:0] sync_b;
  logic en_a;
  logic en_b;
  logic soft_rst;  // Power-on reset or chip disabled
  // Held reception values
  logic subc_held;
  logic [7:0] strength_held;
  logic [7:0] next_strength_held;
  logic next_subc_held;
  // Writable registers
  logic [2:0] measure_sel;
  logic [2:0] next_measure_sel;
  logic [23:0] test_setting;
  logic [23:0] next_test_setting;
  logic [1:0] tset_ptr;
  logic [1:0] next_tset_ptr;
  logic [7:0] next_rd_data;
  // Synchronised views
  logic rx_s;
  logic [3:0] gain_s;
  logic subc_s;
  logic [2:0] good_s;
  logic [7:0] strength_s;
  logic [5:0] limit_s;
  logic [7:0] osc_s;
  logic [7:0] status0_value;
  logic [7:0] page_value;

  assign status_raw = {rx_active, gain_level, subc_from_q, rf_level_stable, pll_locked,
                       osc_stable, strength_q, strength_i, gain_limit_i, gain_limit_q,
                       osc_range_result, osc_double_freq, tune_voltage_code};
  assign {rx_s, gain_s, subc_s, good_s, strength_s, limit_s, osc_s} = sync_b;
  assign soft_rst = rst | ~en_b;

  // Two-stage synchroniser; the enable pin shares the same treatment
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
      en_a <= 1'b0;
      en_b <= 1'b0;
    end else begin
      sync_a <= status_raw;
      sync_b <= sync_a;
      en_a <= chip_en;
      en_b <= en_a;
    end
  end

  // Picks a byte out of the 24-bit test setting, first byte is the top one
  function automatic logic [7:0] tset_byte(input logic [23:0] v, input logic [1:0] p);
    logic [7:0] b;
    b = v[23:16];
    if (p == TSET_BYTE_STEP) begin
      b = v[15:8];
    end else if (p == TSET_BYTE_LAST) begin
      b = v[7:0];
    end
    return b;
  endfunction

  // Status word and paged view, assembled from live and held values
  always_comb begin
    status0_value = {gain_s, subc_held, good_s};
    if (test_setting[TS_PAGE_SELECT +: 2] == PAGE_GAIN_LIMIT) begin
      page_value = {2'h0, limit_s};
    end else if (test_setting[TS_PAGE_SELECT +: 2] == PAGE_OSC_RANGE) begin
      page_value = osc_s;
    end else begin
      // Undefined pages read as zero
      page_value = READ_IDLE;
    end
  end

  // Next values of held status, writable registers and read data
  always_comb begin
    next_subc_held = subc_held;
    next_strength_held = strength_held;
    next_measure_sel = measure_sel;
    next_test_setting = test_setting;
    next_tset_ptr = tset_ptr;
    next_rd_data = reg_rd_data;
    // Values only move while receiving, so they stay valid up to the next reception
    if (rx_s) begin
      next_subc_held = subc_s;
      next_strength_held = strength_s;
    end
    // Writes: only the two configuration registers take data
    if (reg_wr) begin
      if (reg_addr == ADDR_MEASURE_SELECT) begin
        next_measure_sel = reg_wr_data[2:0];
      end else if (reg_addr == ADDR_TEST_SETTING) begin
        if (tset_ptr == TSET_BYTE_FIRST) begin
          next_test_setting[23:16] = reg_wr_data & TEST_SETTING_MASK[23:16];
        end else if (tset_ptr == TSET_BYTE_STEP) begin
          next_test_setting[15:8] = reg_wr_data & TEST_SETTING_MASK[15:8];
        end else begin
          next_test_setting[7:0] = reg_wr_data & TEST_SETTING_MASK[7:0];
        end
      end
      // Other addresses, status ones included, are dropped here
    end
    // Reads: registered one cycle after the strobe
    if (reg_rd) begin
      if (reg_addr == ADDR_GAIN_STATUS) begin
        next_rd_data = status0_value;
      end else if (reg_addr == ADDR_SIGNAL_STRENGTH) begin
        next_rd_data = strength_held;
      end else if (reg_addr == ADDR_LIMIT_OR_OSC) begin
        next_rd_data = page_value;
      end else if (reg_addr == ADDR_MEASURE_SELECT) begin
        next_rd_data = {5'h00, measure_sel};
      end else if (reg_addr == ADDR_TEST_SETTING) begin
        next_rd_data = tset_byte(test_setting, tset_ptr);
      end else if (reg_addr == ADDR_CHIP_VERSION) begin
        next_rd_data = CHIP_VERSION;
      end else begin
        next_rd_data = READ_IDLE;
      end
    end
    // Byte pointer walks the three bytes, then restarts; an access end rewinds it
    if (access_end) begin
      next_tset_ptr = TSET_BYTE_FIRST;
    end else if ((reg_wr || reg_rd) && reg_addr == ADDR_TEST_SETTING) begin
      if (tset_ptr == TSET_BYTE_LAST) begin
        next_tset_ptr = TSET_BYTE_FIRST;
      end else begin
        next_tset_ptr = tset_ptr + TSET_BYTE_STEP;
      end
    end
  end

  // Register stage; configuration clears on reset or while disabled
  always_ff @(posedge clk_sys) begin
    if (soft_rst) begin
      measure_sel <= MEASURE_RESET;
      test_setting <= TEST_SETTING_RESET;
      tset_ptr <= TSET_BYTE_FIRST;
      subc_held <= 1'b0;
      strength_held <= READ_IDLE;
      reg_rd_data <= READ_IDLE;
    end else begin
      measure_sel <= next_measure_sel;
      test_setting <= next_test_setting;
      tset_ptr <= next_tset_ptr;
      subc_held <= next_subc_held;
      strength_held <= next_strength_held;
      reg_rd_data <= next_rd_data;
    end
  end

  // Field outputs; a nonzero test setting is a host misuse we do not block
  assign measure_source = measure_sel;
  assign analog_test_group_a = test_setting[TS_TEST_GROUP_A +: 3];
  assign analog_test_group_b = test_setting[TS_TEST_GROUP_B +: 3];
  assign decoder_speedup = test_setting[TS_DECODER_SPEEDUP];
  assign status_page_select = test_setting[TS_PAGE_SELECT +: 2];
  assign strength_continuous = test_setting[TS_STRENGTH_CONT];
  assign gain_control_type = test_setting[TS_GAIN_CONTROL_TYPE];
  assign rx_output_block = test_setting[TS_RX_BLOCK +: 2];
  assign digital_filter_off = test_setting[TS_DIG_FILTER_OFF];
  assign subc_input_enable = test_setting[TS_SUBC_IN];
  assign subc_output_enable = test_setting[TS_SUBC_OUT];
  assign prescaler_test = test_setting[TS_PRESCALER_TEST];
  assign extra_test = test_setting[TS_EXTRA_TEST +: 2];

  // Checks
  // A back-to-back write pair on the test setting register
  sequence tset_first_wr;
    reg_wr && reg_addr == ADDR_TEST_SETTING && tset_ptr == TSET_BYTE_FIRST && !access_end;
  endsequence
  sequence tset_second_wr;
    reg_wr && reg_addr == ADDR_TEST_SETTING && !access_end;
  endsequence

  tset_bytes_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    tset_first_wr ##1 tset_second_wr |=> test_setting[15:8] ==
      ($past(reg_wr_data) & TEST_SETTING_MASK[15:8]) && tset_ptr == TSET_BYTE_LAST)
    else $error("test setting second byte not stored");
  gain_status_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    reg_rd && reg_addr == ADDR_GAIN_STATUS |=> reg_rd_data[7:4] == $past(gain_s))
    else $error("gain level read mismatch");
  status_flags_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    reg_rd && reg_addr == ADDR_GAIN_STATUS |=> reg_rd_data[2:0] == $past(good_s)
      && reg_rd_data[3] == $past(subc_held, 1))
    else $error("status flags read mismatch");
  strength_hold_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    !rx_s |=> $stable(strength_held) && $stable(subc_held))
    else $error("strength changed outside reception");
  strength_take_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    rx_s |=> strength_held == $past(strength_s) && subc_held == $past(subc_s))
    else $error("strength not captured in reception");
  gain_page_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    reg_rd && reg_addr == ADDR_LIMIT_OR_OSC && status_page_select == PAGE_GAIN_LIMIT
      |=> reg_rd_data == {2'h0, $past(limit_s)})
    else $error("gain limit page mismatch");
  osc_page_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    reg_rd && reg_addr == ADDR_LIMIT_OR_OSC && status_page_select == PAGE_OSC_RANGE
      |=> reg_rd_data == $past(osc_s))
    else $error("oscillator page mismatch");
  measure_clear_a: assert property (@(posedge clk_sys)
    soft_rst |=> measure_source == MEASURE_RESET && test_setting == TEST_SETTING_RESET)
    else $error("configuration not cleared");
  status_ro_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    reg_wr && reg_addr != ADDR_MEASURE_SELECT && reg_addr != ADDR_TEST_SETTING
      |=> $stable(measure_sel) && $stable(test_setting))
    else $error("write to status register took effect");
  version_read_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    reg_rd && reg_addr == ADDR_CHIP_VERSION |=> reg_rd_data == CHIP_VERSION)
    else $error("version read mismatch");
  measure_write_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    reg_wr && reg_addr == ADDR_MEASURE_SELECT |=> measure_source == $past(reg_wr_data[2:0]))
    else $error("measure select not stored");
  // An access end must leave the pointer on the top byte, or the next host
  // access would land its first byte in the wrong third of the register
  ptr_rewind_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    access_end |=> tset_ptr == TSET_BYTE_FIRST)
    else $error("byte pointer not rewound");
  // Strength reads return the held pair, not the live synchronised one
  strength_read_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    reg_rd && reg_addr == ADDR_SIGNAL_STRENGTH |=> reg_rd_data == $past(strength_held))
    else $error("strength read mismatch");
  // Reserved bits of the measurement select read back as zero
  measure_read_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
    reg_rd && reg_addr == ADDR_MEASURE_SELECT |=> reg_rd_data == {5'h00, $past(measure_sel)})
    else $error("measure select read mismatch");
endmodule
